// ---- common/btc_pkg.sv ----
// Package for the background timer/counter: register map, fields, constants.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
package btc_pkg;
	// Register byte offsets
	localparam logic [3:0] CTRL_OFF    = 4'h0;
	localparam logic [3:0] TIMER_OFF   = 4'h4;
	localparam logic [3:0] FLAGS_OFF   = 4'h8;
	localparam logic [3:0] MASK_OFF    = 4'hC;
	localparam int         ADDR_W      = 4;
	// Control word fields: [1:0] command, [31:16] preload
	localparam int         CMD_LSB     = 0;
	localparam int         PRE_LSB     = 16;
	// Status bit positions in the flags byte
	localparam int         OVF_BIT     = 7;
	localparam logic [7:0] FLAGS_USED  = 8'h80;
	localparam logic [7:0] MASK_RESET  = 8'h00;
	// One-second preload constants per core clock
	localparam logic [15:0] one_second_preload_4mhz  = 16'hC2F6; // R2
	localparam logic [15:0] one_second_preload_8mhz  = 16'h85EE; // R2
	localparam logic [15:0] one_second_preload_16mhz = 16'h0BDC; // R2
	localparam logic [15:0] PRELOAD_RESET = 16'h0000;
	localparam logic [15:0] TIMER_RESET   = 16'h0000;
	// Minor tick divides the clock by this many periods
	localparam int          MINOR_DIV     = 256;
	localparam logic [7:0]  MINOR_LAST    = 8'(MINOR_DIV - 1);
	// AXI responses
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	// Configuration commands
	typedef enum logic [1:0] {
		CMD_OFF      = 2'b00,
		CMD_INTERNAL = 2'b01,
		CMD_EXTERNAL = 2'b10,
		CMD_SPARE    = 2'b11
	} btc_cmd_type;
	// Command carried from the bus slave to the core
	typedef struct packed {
		logic        strobe;
		btc_cmd_type cmd;
		logic [15:0] preload;
	} btc_cfg_type;
endpackage

// ---- core/btc_edge_detect.sv ----
// Synchroniser and rising edge detector for the external count pin.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module btc_edge_detect
	import btc_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// Pin and detected edge
	input  wire logic pinIn,
	output logic      risePulse
);
	logic syncA;
	logic syncB;
	logic prevB;

	// Two stages before anything looks at the pin
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			prevB <= 1'b0;
		end else begin
			syncA <= pinIn;
			syncB <= syncA;
			prevB <= syncB;
		end
	end

	// Positive-going edge only
	assign risePulse = syncB & ~prevB;
endmodule
`default_nettype wire

// ---- core/btc_minor_tick.sv ----
// Free-running divider giving one minor tick every 256 clock periods.
// Assumes a single clock domain; runs only while enabled.
`timescale 1ns/1ps
`default_nettype none
module btc_minor_tick
	import btc_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// Control and tick
	input  wire logic run,
	input  wire logic restart,
	output logic      tick
);
	logic [7:0] divCount;

	// Restart aligns the first tick with the configuring command
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			divCount <= 8'h00;
		end else if (restart || !run) begin
			divCount <= 8'h00;
		end else begin
			divCount <= divCount + 8'h01;
		end
	end

	assign tick = run && !restart && (divCount == MINOR_LAST); // R13
endmodule
`default_nettype wire

// ---- core/btc_top.sv ----
// Background timer/counter with AXI4-Lite registers and a level interrupt.
// Assumes one 50 MHz clock, count pin asynchronous to it.
//
// Operation
// R1: Commands: off, internal timer with preload, external count with preload.
// R2: Preload constants 49910, 34286 and 3036 give one-second ticks.
// R3: Works as internal timer or counter of external pulses on input zero.
// R4: External mode: hidden counter steps on each rising edge of input.
// R5: Counting runs in background without stalling anything else.
// R6: Hidden counter wrap from 65535 increments the visible timer word.
// R7: Hidden counter starts at preload; preload 65535 counts every pulse.
// R8: Timer word wrap from 65535 sets the overflow flag.
// R9: Overflow flag cleared by any command and by software clearing it; code clears it only on a legal command written with all four strobes.
// R10: Overflow flag can drive the interrupt.
// R11: Timer suspends while a debug dump is transmitted.
// R12: On one variant external count mode is absent.
// R13: Internal mode: minor tick every 256 clocks; hidden wrap is major tick.
// R14: Hidden counter reloads with preload after every wrap.
// R15: Overflow flag sits at bit seven of the flags byte.
// R16: Off stops both counters; timer word holds its value.
`timescale 1ns/1ps
`default_nettype none
module btc_top
	import btc_pkg::*;
#(
	parameter bit HAS_EXTERNAL = 1'b1
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Count pin and debug suspend
	input  wire logic        countPin,
	input  wire logic        debugBusy,
	// Interrupt
	output logic             irq
);
	// Write channel holding registers
	logic              awHeld;
	logic [ADDR_W-1:0] awAddr;
	logic              wHeld;
	logic [31:0]       wData;
	logic [3:0]        wStrb;
	// Core state
	btc_cmd_type       mode;
	logic [15:0]       preload;
	logic [15:0]       hidden;
	logic [15:0]       timerWord;
	logic              ovfFlag;
	logic [7:0]        irqMask;
	logic              debugA;
	logic              debugB;
	btc_cfg_type       cfg;

	// Write accepted once both halves are held and no response pends
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;

	wire logic doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire logic [ADDR_W-1:0] wrAddr = awAddr;
	wire logic wrCtrl  = doWrite && (wrAddr == CTRL_OFF);
	wire logic wrTimer = doWrite && (wrAddr == TIMER_OFF);
	wire logic wrFlags = doWrite && (wrAddr == FLAGS_OFF);
	wire logic wrMask  = doWrite && (wrAddr == MASK_OFF);
	wire logic wrHit   = wrCtrl || wrTimer || wrFlags || wrMask;

	// Address and data may arrive in either order
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld <= 1'b0;
			awAddr <= '0;
			wHeld  <= 1'b0;
			wData  <= 32'h0000_0000;
			wStrb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr[ADDR_W-1:0];
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Decode the control write into a command; the full word is needed
	wire btc_cmd_type reqCmd = btc_cmd_type'(wData[CMD_LSB +: 2]);
	wire logic extAllowed = HAS_EXTERNAL; // R12
	wire logic cmdLegal = (reqCmd == CMD_OFF) || (reqCmd == CMD_INTERNAL)
		|| ((reqCmd == CMD_EXTERNAL) && extAllowed);
	assign cfg.strobe  = wrCtrl && (&wStrb) && cmdLegal; // R1
	assign cfg.cmd     = reqCmd;
	assign cfg.preload = wData[PRE_LSB +: 16];

	// Debug dump indication crosses in through two stages
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			debugA <= 1'b0;
			debugB <= 1'b0;
		end else begin
			debugA <= debugBusy;
			debugB <= debugA;
		end
	end

	// Event sources
	logic minorTick;
	logic pinRise;

	btc_minor_tick u_minor (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.run     (mode == CMD_INTERNAL),
		.restart (cfg.strobe),
		.tick    (minorTick)
	);

	btc_edge_detect u_edge (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.pinIn     (countPin),
		.risePulse (pinRise)
	);

	// Pick the event that feeds the hidden counter
	wire logic extStep = (mode == CMD_EXTERNAL) && pinRise; // R3 R4
	wire logic intStep = (mode == CMD_INTERNAL) && minorTick; // R13
	wire logic step = (extStep || intStep) && !debugB && !cfg.strobe; // R5 R11 R16
	wire logic hiddenWrap = step && (hidden == 16'hFFFF); // R6
	wire logic timerWrap = hiddenWrap && (timerWord == 16'hFFFF); // R8

	// Mode and preload take effect on a legal command
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode    <= CMD_OFF;
			preload <= PRELOAD_RESET;
		end else if (cfg.strobe) begin
			mode    <= cfg.cmd;
			preload <= cfg.preload;
		end
	end

	// Hidden counter starts at and reloads with preload
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hidden <= PRELOAD_RESET;
		end else if (cfg.strobe) begin
			hidden <= cfg.preload; // R7
		end else if (hiddenWrap) begin
			hidden <= preload; // R14
		end else if (step) begin
			hidden <= hidden + 16'h0001;
		end
	end

	// Timer word keeps its value while off
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			timerWord <= TIMER_RESET;
		end else if (wrTimer) begin
			timerWord <= wData[15:0];
		end else if (hiddenWrap) begin
			timerWord <= timerWord + 16'h0001; // R6
		end
	end

	// Overflow flag: a new overflow wins over a software clear
	wire logic swClear = wrFlags && wStrb[0] && !wData[OVF_BIT]; // R9
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ovfFlag <= 1'b0;
		end else if (timerWrap) begin
			ovfFlag <= 1'b1; // R8
		end else if (cfg.strobe || swClear) begin
			ovfFlag <= 1'b0; // R9
		end
	end

	// Mask register, same layout as the flags byte
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irqMask <= MASK_RESET;
		end else if (wrMask && wStrb[0]) begin
			irqMask <= wData[7:0] & FLAGS_USED;
		end
	end

	wire logic [7:0] flags_bit_seven_byte = {ovfFlag, 7'h00}; // R15
	assign irq = |(flags_bit_seven_byte & irqMask); // R10

	// Read side: one read in flight, answered the cycle after address
	wire logic [ADDR_W-1:0] rdAddr = s_axi_araddr[ADDR_W-1:0];
	wire logic rdHit = (rdAddr == CTRL_OFF) || (rdAddr == TIMER_OFF)
		|| (rdAddr == FLAGS_OFF) || (rdAddr == MASK_OFF);
	wire logic [31:0] rdCtrl = {preload, 14'h0000, mode};
	wire logic [31:0] rdMux =
		(rdAddr == CTRL_OFF)  ? rdCtrl :
		(rdAddr == TIMER_OFF) ? {16'h0000, timerWord} :
		(rdAddr == FLAGS_OFF) ? {24'h00_0000, flags_bit_seven_byte} :
		(rdAddr == MASK_OFF)  ? {24'h00_0000, irqMask} : 32'h0000_0000;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdMux;
			s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- tb/btc_checker.sv ----
// Checker for btc_top: bus answers and interrupt clearing.
// Assumes the port names of btc_top; bound after the module.
`timescale 1ns/1ps
`default_nettype none
module btc_checker (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        arst_n,
	// Bus and interrupt
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// Address and data taken at one edge
	sequence wBoth;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// A write that must leave irq low once applied
	property lowAfter(a, c);
		wBoth ##0 (s_axi_awaddr[3:0] == a && c) |-> ##2 !irq;
	endproperty
	AST_WR_ANSWER: assert property (wBoth |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read not answered");
	AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid) else $error("read answer dropped");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_W_REFUSE: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	AST_FLAG_CLR: assert property (lowAfter(4'h8,
		!s_axi_wdata[7] && s_axi_wstrb[0])) else $error("flag not cleared");
	AST_CMD_CLR: assert property (lowAfter(4'h0,
		s_axi_wstrb == 4'hF && s_axi_wdata[1:0] != 2'h3))
		else $error("command left flag set");
	AST_MASK_OFF: assert property (lowAfter(4'hC,
		!s_axi_wdata[7] && s_axi_wstrb[0])) else $error("masked irq high");
endmodule
bind btc_top btc_checker btc_checker_inst (.mclk(mclk), .arst_n(arst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// ---- tb/btc_pulse_src.sv ----
// Far-side pulse source on the count pin.
// Assumes the bench calls its task just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module btc_pulse_src (
	// Clock
	input wire logic mclk,
	// Count pin
	output logic     pin
);
	// Idle low between bursts
	initial pin = 1'b0;
	// Burst of n pulses, w cycles high and w low; large w is slow
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			repeat (w) @(posedge mclk);
			pin <= 1'b1;
			repeat (w) @(posedge mclk);
			pin <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/test_btc_top.sv ----
// Testbench for btc_top: counting, overflow, interrupt and bus.
// Assumes btc_pkg, the pulse source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_btc_top
	import btc_pkg::*;
;
	// One ordinary case
	typedef struct packed {
		btc_cmd_type cmd;
		logic [15:0] pre;
		logic [7:0]  ev;
		logic        dbg;
		logic [15:0] exp;
	} btc_row_type;
	btc_row_type rows [6] = '{
		'{CMD_EXTERNAL, 16'hFFFF, 8'h03, 1'b0, 16'h0003},
		'{CMD_EXTERNAL, 16'hFFF6, 8'h0A, 1'b0, 16'h0001},
		'{CMD_EXTERNAL, 16'hFFFB, 8'h0D, 1'b0, 16'h0002},
		'{CMD_OFF,      16'hFFFF, 8'h03, 1'b0, 16'h0000},
		'{CMD_EXTERNAL, 16'hFFFF, 8'h03, 1'b1, 16'h0000},
		'{CMD_INTERNAL, 16'hFFFE, 8'h05, 1'b0, 16'h0002}};
	logic        mclk = 1'b0, arst_n = 1'b0, av = 1'b0, wv = 1'b0;
	logic        br = 1'b0, arv = 1'b0, rr = 1'b0, dbg = 1'b0;
	logic        lateReady = 1'b0; // Holds bready/rready back a while
	logic        aR, wR, bV, arR, rV, irq, pin;
	logic [31:0] aa = '0, wd = '0, ra = '0, rD, q;
	logic [3:0]  ws = '0;
	logic [1:0]  bResp, rResp, r;
	int          n_fail = 0, check_count = 0;
	always #10 mclk = ~mclk;
	btc_top btc_top_inst (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(aa),
		.s_axi_awvalid(av), .s_axi_awready(aR), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wR),
		.s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(br),
		.s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arR),
		.s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
		.s_axi_rready(rr), .countPin(pin), .debugBusy(dbg), .irq(irq));
	btc_pulse_src btc_pulse_src_inst (.mclk(mclk), .pin(pin));
	task automatic conclude;
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One transfer; handshakes sampled mid-cycle to stay off the edge
	task automatic xfer(input logic rd, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, done;
		done = 1'b0;
		@(posedge mclk);
		ra <= 32'(a);
		aa <= 32'(a);
		wd <= d;
		ws <= s;
		arv <= rd;
		rr <= rd && !lateReady;
		av <= !rd;
		wv <= !rd;
		br <= !rd && !lateReady;
		for (int k = 0; k < 64 && !done; k++) begin
			@(negedge mclk);
			ta = rd ? arv && arR : av && aR;
			tw = wv && wR;
			done = rd ? rV && rr : bV && br;
			q = rD;
			r = rd ? rResp : bResp;
			@(posedge mclk);
			if (ta) begin
				av <= 1'b0;
				arv <= 1'b0;
			end
			if (tw) wv <= 1'b0;
			if (done) begin
				br <= 1'b0;
				rr <= 1'b0;
			end else if (k == 2) begin
				rr <= rd;
				br <= !rd;
			end
		end
		if (!done) begin
			$display("CHECK FAILED answer expected 1 seen 0");
			n_fail++;
			conclude();
		end
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		chk("irq", 32'h0000_0000, 32'(irq));
		xfer(1'b1, CTRL_OFF, '0, '0); chk("ctrl", 32'h0000_0000, q);
		xfer(1'b1, TIMER_OFF, '0, '0); chk("timer", 32'h0000_0000, q);
		chk("pre4", 32'h0000_C2F6, 32'(one_second_preload_4mhz));
		chk("pre8", 32'h0000_85EE, 32'(one_second_preload_8mhz));
		chk("pre16", 32'h0000_0BDC, 32'(one_second_preload_16mhz));
		// Ordinary cases: timer cleared, command, events, read back
		foreach (rows[j]) begin
			dbg <= rows[j].dbg;
			xfer(1'b0, TIMER_OFF, '0, 4'hF);
			xfer(1'b0, CTRL_OFF, {rows[j].pre, 14'h0, rows[j].cmd}, 4'hF);
			if (rows[j].cmd == CMD_INTERNAL)
				repeat (rows[j].ev * MINOR_DIV + 16) @(posedge mclk);
			else
				btc_pulse_src_inst.pulses(rows[j].ev, 2 + 6 * (j % 2));
			repeat (8) @(posedge mclk);
			xfer(1'b1, TIMER_OFF, '0, '0);
			chk("timer", 32'(rows[j].exp), q);
		end
		dbg <= 1'b0;
		// Overflow raises irq; writing one keeps it, zero clears it
		xfer(1'b0, MASK_OFF, 32'h0000_0080, 4'hF);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
		xfer(1'b1, MASK_OFF, '0, '0); chk("mask", 32'h0000_0080, q);
		xfer(1'b0, TIMER_OFF, 32'h0000_FFFF, 4'hF);
		xfer(1'b0, CTRL_OFF, 32'hFFFF_0002, 4'hF);
		btc_pulse_src_inst.pulses(1, 2);
		repeat (8) @(posedge mclk);
		chk("irq", 32'h0000_0001, 32'(irq));
		xfer(1'b1, FLAGS_OFF, '0, '0); chk("flags", 32'h0000_0080, q);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
		xfer(1'b0, FLAGS_OFF, 32'h0000_0080, 4'h1);
		chk("irq", 32'h0000_0001, 32'(irq));
		xfer(1'b0, FLAGS_OFF, '0, 4'h1);
		chk("irq", 32'h0000_0000, 32'(irq));
		// Second overflow; late answers, command clears a raised irq
		xfer(1'b0, TIMER_OFF, 32'h0000_FFFF, 4'hF);
		btc_pulse_src_inst.pulses(1, 2);
		repeat (8) @(posedge mclk);
		lateReady = 1'b1;
		xfer(1'b1, FLAGS_OFF, '0, '0); chk("flags", 32'h0000_0080, q);
		xfer(1'b0, CTRL_OFF, 32'hFFFF_0002, 4'hF);
		lateReady = 1'b0;
		chk("irq", 32'h0000_0000, 32'(irq));
		xfer(1'b1, FLAGS_OFF, '0, '0); chk("flags", 32'h0000_0000, q);
		// Masked overflow keeps the flag but drops irq
		xfer(1'b0, TIMER_OFF, 32'h0000_FFFF, 4'hF);
		btc_pulse_src_inst.pulses(1, 2);
		repeat (8) @(posedge mclk);
		chk("irq", 32'h0000_0001, 32'(irq));
		xfer(1'b0, MASK_OFF, '0, 4'hF);
		chk("irq", 32'h0000_0000, 32'(irq));
		xfer(1'b1, FLAGS_OFF, '0, '0); chk("flags", 32'h0000_0080, q);
		// Spare code and partial strobes leave mode and flag alone
		xfer(1'b0, CTRL_OFF, 32'h1234_0003, 4'hF);
		xfer(1'b0, CTRL_OFF, 32'h0000_0000, 4'h3);
		xfer(1'b1, CTRL_OFF, '0, '0); chk("ctrl", 32'hFFFF_0002, q);
		xfer(1'b1, FLAGS_OFF, '0, '0); chk("flags", 32'h0000_0080, q);
		// Unmapped place is refused
		xfer(1'b0, 4'h2, '0, 4'hF);
		chk("bresp", 32'(RESP_SLVERR), 32'(r));
		xfer(1'b1, 4'h2, '0, '0);
		chk("resp", 32'(RESP_SLVERR), 32'(r));
		conclude();
	end
endmodule
`default_nettype wire
